/* sca_channel_array.v */
// Four-channel serial array with clocked serial function per channel
// What this block does
// - Four channels, each may run its own interface type, except that async on one bars clocked serial on its pair.
// - Clocked serial on u0 ch0, ch1, ch2 and u1 ch0; two-wire on u0ch2, u1ch0.
// - Unit 1 channels 2 and 3 belong to the async port; no clocked serial.
// - An async pair disables clocked serial on both channels of that pair.
// - Clocked serial uses clock, data in and data out, both shifting on clock.
// - Frame length is seven or eight bits; partner must match.
// - Data phase selects which clock edge launches and samples data.
// - Clock phase selects idle level and active polarity, master or slave.
// - Software selects MSB first or LSB first.
// - Transmit and receive data may be inverted.
// - Master bit clock is shared prescaler output divided per channel.
// - Interrupt at transfer end or at transmit buffer empty, as selected.
`timescale 1ns/100ps
`include "sca_defines.vh"
module sca_channel_array #(
  parameter UNIT_ID = 1'b0
)
(
  input wire clock,
  input wire rst_n,
  input wire [`SCA_PRE_W-1:0] prescale,
  input wire [7:0] ch_function,
  input wire [3:0] ch_enable,
  input wire [3:0] ch_master,
  input wire [3:0] ch_len7,
  input wire [3:0] ch_data_phase,
  input wire [3:0] ch_clock_phase,
  input wire [3:0] ch_lsb_first,
  input wire [3:0] ch_invert,
  input wire [3:0] ch_irq_on_empty,
  input wire [27:0] ch_divider,
  input wire [31:0] tx_data,
  input wire [3:0] tx_valid,
  output reg [3:0] tx_ready,
  output reg [31:0] rx_data,
  output reg [3:0] rx_valid,
  input wire [3:0] rx_read,
  input wire [3:0] overrun_clear,
  output reg [3:0] overrun,
  output reg [3:0] irq,
  output reg [3:0] csi_active,
  output reg [3:0] sck_out,
  output reg [3:0] sck_oe_n,
  input wire [3:0] sck_in,
  input wire [3:0] sdi,
  output reg [3:0] sdo
);
  reg [`SCA_PRE_W-1:0] pre_cnt;
  reg pre_tick;
  wire [3:0] csi_ok;
  wire [3:0] pair_async;
  // Shared prescaler feeds every channel's own divider
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt <= {`SCA_PRE_W{1'b0}};
      pre_tick <= 1'b0;
    end
    else if (pre_cnt >= prescale)
    begin
      pre_cnt <= {`SCA_PRE_W{1'b0}};
      pre_tick <= 1'b1;
    end
    else
    begin
      pre_cnt <= pre_cnt + 1'b1;
      pre_tick <= 1'b0;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      wire [1:0] fn;
      wire [`SCA_DIV_W-1:0] div;
      wire [7:0] fifo_data;
      wire fifo_valid;
      wire fifo_in_ready;
      reg fifo_take;
      reg [1:0] state;
      reg [`SCA_DIV_W-1:0] div_cnt;
      reg [7:0] shreg;
      reg [7:0] rxsh;
      reg [3:0] bit_cnt;
      reg sck_prev;
      reg sck_armed;
      reg busy;
      wire lead_edge;
      wire trail_edge;
      wire [3:0] frame_bits;
      wire out_bit;
      assign fn = ch_function[2*g+1:2*g];
      assign div = ch_divider[7*g+6:7*g];
      assign frame_bits = ch_len7[g] ? `SCA_LEN_SHORT : `SCA_LEN_LONG;
      // Channel availability: fixed map plus async pair lockout
      assign pair_async[g] = (ch_function[2*(g^1)+1:2*(g^1)] == `SCA_FN_ASYNC)
        || (fn == `SCA_FN_ASYNC);
      assign csi_ok[g] = (UNIT_ID ? (g == 0) : (g != 3)) && !pair_async[g];
      // Slave clock edges; no edge until sck_prev holds a real pin sample after reset
      assign lead_edge = sck_armed && (sck_in[g] != sck_prev)
        && (sck_in[g] != ch_clock_phase[g]);
      assign trail_edge = sck_armed && (sck_in[g] != sck_prev)
        && (sck_in[g] == ch_clock_phase[g]);
      assign out_bit = (ch_lsb_first[g] ? shreg[0] : shreg[7]) ^ ch_invert[g];
      sca_fifo #(
        .WIDTH(`SCA_DATA_W),
        .DEPTH(`SCA_FIFO_DEPTH),
        .AW(`SCA_FIFO_AW)
      ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_data(tx_data[8*g+7:8*g]),
        .in_valid(tx_valid[g]),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take)
      );
      // Frame loads only when idle; while busy the FIFO keeps taking writes until it is full
      always @*
      begin
        fifo_take = (state == `SCA_ST_IDLE) && fifo_valid && ch_enable[g] && csi_ok[g]
          && (fn == `SCA_FN_CSI);
      end
      // Per-channel shift engine, each channel independent
      always @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          state <= `SCA_ST_IDLE;
          div_cnt <= {`SCA_DIV_W{1'b0}};
          shreg <= 8'h00;
          rxsh <= 8'h00;
          bit_cnt <= 4'h0;
          sck_prev <= 1'b0;
          sck_armed <= 1'b0;
          busy <= 1'b0;
          sck_out[g] <= 1'b0;
          sck_oe_n[g] <= 1'b1;
          sdo[g] <= 1'b0;
          rx_data[8*g+7:8*g] <= 8'h00;
          rx_valid[g] <= 1'b0;
          overrun[g] <= 1'b0;
          irq[g] <= 1'b0;
          tx_ready[g] <= 1'b0;
          csi_active[g] <= 1'b0;
        end
        else
        begin
          sck_prev <= sck_in[g];
          sck_armed <= 1'b1;
          tx_ready[g] <= fifo_in_ready;
          csi_active[g] <= csi_ok[g] && (fn == `SCA_FN_CSI) && ch_enable[g];
          sck_oe_n[g] <= !(ch_master[g] && csi_ok[g] && ch_enable[g]);
          irq[g] <= 1'b0;
          if (rx_read[g])
            rx_valid[g] <= 1'b0;
          if (overrun_clear[g])
            overrun[g] <= 1'b0;
          if (busy)
            div_cnt <= (pre_tick && div_cnt != 7'h00) ? div_cnt - 1'b1 : div_cnt;
          case (state)
            `SCA_ST_IDLE:
            begin
              sck_out[g] <= ch_clock_phase[g];
              if (fifo_take)
              begin
                shreg <= fifo_data;
                bit_cnt <= 4'h0;
                busy <= 1'b1;
                div_cnt <= div;
                state <= `SCA_ST_FIRST;
                if (ch_irq_on_empty[g])
                  irq[g] <= 1'b1;
                // Phase 0 presents the first bit before any clock edge
                if (!ch_data_phase[g])
                  sdo[g] <= (ch_lsb_first[g] ? fifo_data[0] : fifo_data[7]) ^ ch_invert[g];
              end
            end
            `SCA_ST_FIRST:
            begin
              // Leading half bit: master waits on divider, slave on clock edge
              if (ch_master[g] ? (pre_tick && div_cnt == 7'h00) : lead_edge)
              begin
                div_cnt <= div;
                if (ch_master[g])
                  sck_out[g] <= !ch_clock_phase[g];
                if (ch_data_phase[g])
                  sdo[g] <= out_bit;
                else
                  rxsh <= {rxsh[6:0], sdi[g] ^ ch_invert[g]};
                state <= `SCA_ST_SECOND;
              end
            end
            `SCA_ST_SECOND:
            begin
              if (ch_master[g] ? (pre_tick && div_cnt == 7'h00) : trail_edge)
              begin
                div_cnt <= div;
                if (ch_master[g])
                  sck_out[g] <= ch_clock_phase[g];
                if (ch_data_phase[g])
                  rxsh <= {rxsh[6:0], sdi[g] ^ ch_invert[g]};
                shreg <= ch_lsb_first[g] ? {1'b0, shreg[7:1]} : {shreg[6:0], 1'b0};
                bit_cnt <= bit_cnt + 1'b1;
                if (bit_cnt + 4'h1 == frame_bits)
                  state <= `SCA_ST_DONE;
                else
                begin
                  state <= `SCA_ST_FIRST;
                  if (!ch_data_phase[g])
                    sdo[g] <= (ch_lsb_first[g] ? shreg[1] : shreg[6]) ^ ch_invert[g];
                end
              end
            end
            `SCA_ST_DONE:
            begin
              busy <= 1'b0;
              state <= `SCA_ST_IDLE;
              // Sampled bits sit in low bits; reorder for LSB first framing
              if (ch_lsb_first[g])
                rx_data[8*g+7:8*g] <= ch_len7[g] ? {1'b0, rxsh[0], rxsh[1], rxsh[2],
                  rxsh[3], rxsh[4], rxsh[5], rxsh[6]} : {rxsh[0], rxsh[1], rxsh[2],
                  rxsh[3], rxsh[4], rxsh[5], rxsh[6], rxsh[7]};
              else
                rx_data[8*g+7:8*g] <= ch_len7[g] ? {1'b0, rxsh[6:0]} : rxsh;
              rx_valid[g] <= 1'b1;
              // Overrun set wins over a same-cycle clear; a same-cycle read prevents the set
              if (rx_valid[g] && !rx_read[g])
                overrun[g] <= 1'b1;
              if (!ch_irq_on_empty[g])
                irq[g] <= 1'b1;
            end
            default:
              state <= `SCA_ST_IDLE;
          endcase
          // Disable aborts the frame at once
          if (!ch_enable[g] || !csi_ok[g])
          begin
            state <= `SCA_ST_IDLE;
            busy <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule

/* sca_defines.vh */
// Shared constants of the clocked serial channel array
`ifndef SCA_DEFINES_VH
`define SCA_DEFINES_VH
`define SCA_CHANNELS 4
`define SCA_DATA_W 8
`define SCA_FIFO_DEPTH 16
`define SCA_FIFO_AW 4
`define SCA_PRE_W 4
`define SCA_DIV_W 7
`define SCA_LEN_SHORT 4'h7
`define SCA_LEN_LONG 4'h8
`define SCA_FN_CSI 2'h0
`define SCA_FN_ASYNC 2'h1
`define SCA_FN_TWO_WIRE 2'h2
`define SCA_FN_OFF 2'h3
`define SCA_CSI_OK_MAP 4'h7
`define SCA_TWI_OK_MAP 4'h6
`define SCA_ST_IDLE 2'h0
`define SCA_ST_FIRST 2'h1
`define SCA_ST_SECOND 2'h2
`define SCA_ST_DONE 2'h3
`endif

/* sca_fifo.v */
// Transmit data FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sca_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  input wire clock,
  input wire rst_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire [AW:0] count;
  wire [AW:0] held;
  wire stored_empty;
  wire pop;
  assign count = wr_ptr - rd_ptr;
  // The output register counts as one slot, so the writer never gets more than DEPTH words in
  assign held = count + {{AW{1'b0}}, out_valid};
  assign in_ready = (held != DEPTH[AW:0]);
  assign stored_empty = (count == {(AW+1){1'b0}});
  // Refill the output register when it empties or is consumed
  assign pop = !stored_empty && (!out_valid || out_ready);
  // Storage write, no reset needed on data
  always @(posedge clock)
  begin
    if (in_valid && in_ready)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
  // Pointers and registered read port
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      out_data <= {WIDTH{1'b0}};
      out_valid <= 1'b0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
      begin
        out_data <= mem[rd_ptr[AW-1:0]];
        rd_ptr <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule

/* sca_peer.sv */
// Behavioural clocked serial partner on channel 0, following the channel's phase settings
`timescale 1ns/100ps
module sca_peer (
  input wire sck,
  input wire idle,
  input wire late,
  input wire [3:0] bits,
  input wire mosi,
  output reg miso,
  output reg [7:0] got
);
  reg [7:0] sh;
  reg [7:0] nxt;
  reg [7:0] rx;
  reg seen;
  integer cnt;
  initial
  begin
    sh = 8'h5A;
    nxt = 8'h95;
    rx = 8'h00;
    got = 8'h00;
    miso = 1'b0;
    seen = 1'b0;
    cnt = 0;
  end
  // Phase 0 samples on the leading edge, phase 1 on the trailing one
  always @(sck)
  begin
    if (sck !== idle)
    begin
      seen = 1'b1;
      if (late)
        miso = sh[7];
      else
        rx = {rx[6:0], mosi};
    end
    // A change of idle level alone is not a trailing edge
    else if (seen)
    begin
      seen = 1'b0;
      if (late)
        rx = {rx[6:0], mosi};
      cnt = cnt + 1;
      if (cnt == bits)
      begin
        got = rx;
        rx = 8'h00;
        sh = nxt;
        nxt = nxt + 8'h3B;
        cnt = 0;
      end
      else
        sh = {sh[6:0], 1'b0};
      // Next bit or next reply sits on the line before the next leading edge
      miso = sh[7];
    end
  end
endmodule

/* sca_channel_array_sva.sv */
// Port checker for the clocked serial channel array
`timescale 1ns/100ps
`include "sca_defines.vh"
module sca_channel_array_sva #(
  parameter UNIT_ID = 1'b0
)
(
  input wire clock,
  input wire rst_n,
  input wire [7:0] ch_function,
  input wire [3:0] ch_enable,
  input wire [3:0] ch_master,
  input wire [3:0] ch_irq_on_empty,
  input wire [3:0] rx_read,
  input wire [3:0] overrun_clear,
  input wire [3:0] rx_valid,
  input wire [3:0] overrun,
  input wire [3:0] irq,
  input wire [3:0] csi_active,
  input wire [3:0] sck_oe_n
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence unread;
    rx_valid[0] && !rx_read[0];
  endsequence
  sequence frame_end;
    irq[0] && !ch_irq_on_empty[0];
  endsequence
  active_on_a: assert property (ch_enable[0] && ch_function[3:0] == 4'h0 |=> csi_active[0])
    else $error("ch0 not active");
  active_off_a: assert property (!ch_enable[0] |=> !csi_active[0])
    else $error("ch0 active while off");
  map_gap_a: assert property (!csi_active[3])
    else $error("ch3 active");
  pair_off_a: assert property (ch_function[1:0] == `SCA_FN_ASYNC |=> !csi_active[1])
    else $error("ch1 active beside async");
  slave_oe_a: assert property (!ch_master[0] |=> sck_oe_n[0])
    else $error("slave drives clock");
  irq_pulse_a: assert property (irq[0] |=> !irq[0])
    else $error("irq too long");
  irq_end_a: assert property (!ch_irq_on_empty[0] && $rose(rx_valid[0]) |-> irq[0])
    else $error("no irq at frame end");
  overrun_set_a: assert property (unread ##1 frame_end |-> ##[0:1] overrun[0])
    else $error("overrun missed");
  overrun_hold_a: assert property (overrun[0] && !overrun_clear[0] |=> overrun[0])
    else $error("overrun dropped");
endmodule
bind sca_channel_array sca_channel_array_sva #(.UNIT_ID(UNIT_ID)) u_sva (.clock, .rst_n,
  .ch_function, .ch_enable, .ch_master, .ch_irq_on_empty, .rx_read, .overrun_clear,
  .rx_valid, .overrun, .irq, .csi_active, .sck_oe_n);

/* sca_channel_array_test.sv */
// Self-checking bench for the clocked serial channel array
`timescale 1ns/100ps
module sca_channel_array_test;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] prescale = 4'h1;
  reg [7:0] ch_function = 8'h00;
  reg [3:0] ch_enable = 4'h0, ch_master = 4'h1, ch_lsb_first = 4'h0, ch_invert = 4'h0;
  reg [3:0] tx_valid = 4'h0, rx_read = 4'h0, overrun_clear = 4'h0;
  reg [3:0] ch_len7 = 4'h0, ch_data_phase = 4'h0, ch_clock_phase = 4'h0;
  reg [3:0] ch_irq_on_empty = 4'h0;
  reg [27:0] ch_divider = 28'h0000000;
  reg [31:0] tx_data = 32'h00000000;
  wire [3:0] tx_ready, rx_valid, overrun, irq, csi_active, sck_out, sck_oe_n, sdo, m;
  wire [31:0] rx_data;
  wire [7:0] got;
  wire [3:0] sck_in = sck_out;
  wire [3:0] sdi = {sdo[3:1], m[0]};
  integer num_errors = 0, check_count = 0, seed = 32'h5AA77ED5, i, n;
  reg [7:0] pv = 8'h5A;
  reg [7:0] q [0:15];
  sca_channel_array u_dut (.clock, .rst_n, .prescale, .ch_function, .ch_enable, .ch_master,
    .ch_len7, .ch_data_phase, .ch_clock_phase, .ch_lsb_first, .ch_invert,
    .ch_irq_on_empty, .ch_divider, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
    .rx_read, .overrun_clear, .overrun, .irq, .csi_active, .sck_out, .sck_oe_n, .sck_in,
    .sdi, .sdo);
  sca_peer u_peer (.sck(sck_out[0]), .idle(ch_clock_phase[0]), .late(ch_data_phase[0]),
    .bits(ch_len7[0] ? 4'h7 : 4'h8), .mosi(sdo[0]), .miso(m[0]), .got(got));
  assign m[3:1] = 3'h0;
  initial
    forever #50 clock = ~clock;
  // Expected byte after bit order, level setting and frame length (7-bit keeps top bits)
  function [7:0] fx(input [7:0] v, input l, input x, input s);
    integer j;
    begin
      for (j = 0; j < 8; j = j + 1)
        fx[j] = (s && j == 7) ? 1'b0 : ((l ? v[7 - j] : v[j + s]) ^ x);
    end
  endfunction
  task chk(input [31:0] e, input [31:0] s, input [8*10-1:0] nm);
    begin
      check_count = check_count + 1;
      if (e !== s)
      begin
        num_errors = num_errors + 1;
        $display("wrong value %0s: expected %h, seen %h", nm, e, s);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Back-to-back writes, valid held high between words
  task fill(input integer c);
    begin
      prescale = $random(seed) & 4'h3;
      ch_divider[6:0] = $random(seed) & 7'h03;
      for (i = 0; i < c; i = i + 1)
      begin
        q[i] = $random(seed);
        tx_data[7:0] = q[i];
        tx_valid[0] = 1'b1;
        @(negedge clock);
      end
      tx_valid[0] = 1'b0;
    end
  endtask
  // Frame u is left unread so frame u+1 must flag an overrun; em waits on rx_valid and counts empty-interrupt pulses
  task run(input integer c, input integer u, input l, input x, input s, input em);
    integer k;
    begin
      for (i = 0; i < c; i = i + 1)
      begin
        n = 0;
        k = 0;
        while ((em ? rx_valid[0] : irq[0]) !== 1'b1 && n < 600)
        begin
          if (irq[0] === 1'b1)
            k = k + 1;
          @(negedge clock);
          n = n + 1;
        end
        chk(0, n >= 600, "frame time");
        if (em)
        begin
          chk(i != 0, k, "irq count");
          chk(0, irq[0], "irq at end");
        end
        else
          chk(1, rx_valid[0], "rx_valid");
        chk(fx(q[i], l, x, s), got, "peer");
        chk(fx(pv, l, x, s), rx_data[7:0], "rx_data");
        chk(i == u + 1, overrun[0], "overrun");
        pv = pv + 8'h3B;
        rx_read[0] = (i != u);
        overrun_clear[0] = (i == u + 1);
        @(negedge clock);
        rx_read[0] = 1'b0;
        overrun_clear[0] = 1'b0;
      end
      $display("frames done: %0d", c);
    end
  endtask
  initial
  begin
    #2000000;
    num_errors = num_errors + 1;
    give_verdict;
  end
  initial
  begin
    repeat (5) @(negedge clock);
    chk(4'hF, sck_oe_n, "oe_n");
    chk(0, {irq, rx_valid, overrun, csi_active}, "outputs");
    rst_n = 1'b1;
    @(negedge clock);
    fill(16);
    repeat (2) @(negedge clock);
    chk(0, tx_ready[0], "tx_ready");
    chk(0, csi_active, "active");
    $display("fill done");
    ch_enable = 4'h1;
    run(16, 5, 0, 0, 0, 0);
    ch_lsb_first = 4'h1;
    ch_invert = 4'h1;
    ch_data_phase = 4'h1;
    ch_clock_phase = 4'h1;
    ch_irq_on_empty = 4'h1;
    fill(4);
    run(4, 99, 1, 1, 0, 1);
    ch_lsb_first = 4'h0;
    ch_invert = 4'h0;
    ch_data_phase = 4'h0;
    ch_irq_on_empty = 4'h0;
    ch_len7 = 4'h1;
    fill(4);
    run(4, 99, 0, 0, 1, 0);
    ch_master = 4'h0;
    ch_function = 8'h01;
    ch_enable = 4'hF;
    repeat (3) @(negedge clock);
    chk(4'h4, csi_active, "active");
    chk(4'hF, sck_oe_n, "oe_n");
    $display("refusal done");
    give_verdict;
  end
endmodule
